// ### rtl/icm_master.sv
// Serial bus master engine: write, read and stop operations on a local byte memory
`timescale 1ns/1ps

module icm_master #(
    parameter int ACK_TIMEOUT_CYC = icm_pkg::ACK_TIMEOUT_CYC,
    parameter int DM_AW           = icm_pkg::DM_AW_DEF,
    parameter int CNT_W           = icm_pkg::CNT_W_DEF
) (
    input  wire logic             sys_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             cmd_valid_i,
    input  wire icm_pkg::icm_op_t cmd_op_i,
    input  wire logic [6:0]       cmd_target_address_i,
    input  wire logic [DM_AW-1:0] cmd_start_i,
    input  wire logic [CNT_W-1:0] cmd_count_i,
    output logic                  busy_o,
    output logic                  done_o,
    output logic                  status_o,
    input  wire logic             mem_wr_i,
    input  wire logic [DM_AW-1:0] mem_addr_i,
    input  wire logic [7:0]       mem_wdata_i,
    output logic [7:0]            mem_rdata_o,
    input  wire logic             scl_i,
    output logic                  scl_o,
    output logic                  scl_oe_o,
    input  wire logic             sda_i,
    output logic                  sda_o,
    output logic                  sda_oe_o
);
    import icm_pkg::*;

    localparam int DM_DEPTH = 1 << DM_AW;
    localparam int QC_W     = $clog2(QTR_CYC);
    localparam int TO_W     = $clog2(ACK_TIMEOUT_CYC + 1);

    // Acknowledge is only sampled on a tick, so the limit must span a quarter
    if (QTR_CYC < 2 || ACK_TIMEOUT_CYC <= QTR_CYC || DM_AW < 1 || CNT_W < 1) begin : g_chk
        $error("icm_master: unsupported parameter values");
    end

    logic [7:0]       data_memory [DM_DEPTH];

    icm_state_t       st_q, st_d;
    icm_op_t          op_q, op_d;
    logic [1:0]       ph_q, ph_d;
    logic [7:0]       shift_q, shift_d;
    logic [2:0]       bit_q, bit_d;
    logic             addr_ph_q, addr_ph_d;
    logic             rx_q, rx_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [DM_AW-1:0] idx_q, idx_d;
    logic [TO_W-1:0]  to_q, to_d;
    logic [QC_W-1:0]  qcnt_q, qcnt_d;
    logic             scl_oe_q, scl_oe_d;
    logic             sda_oe_q, sda_oe_d;
    logic             busy_q, busy_d;
    logic             done_q, done_d;
    logic             status_q, status_d;
    logic             held_q, held_d;
    logic             scl_m_q, scl_s_q, sda_m_q, sda_s_q;
    logic [7:0]       mem_rdata_q;
    logic             tick;
    logic             nack_ev;
    logic             mwe;
    logic [DM_AW-1:0] mwa;
    logic [7:0]       mwd;

    assign tick = (qcnt_q == QC_W'(QTR_CYC - 1));

    always_comb begin
        st_d      = st_q;
        op_d      = op_q;
        ph_d      = ph_q;
        shift_d   = shift_q;
        bit_d     = bit_q;
        addr_ph_d = addr_ph_q;
        rx_d      = rx_q;
        cnt_d     = cnt_q;
        idx_d     = idx_q;
        to_d      = to_q;
        qcnt_d    = tick ? '0 : qcnt_q + 1'b1;
        scl_oe_d  = scl_oe_q;
        sda_oe_d  = sda_oe_q;
        busy_d    = busy_q;
        done_d    = 1'b0;
        status_d  = status_q;
        held_d    = held_q;
        nack_ev   = 1'b0;
        mwe       = 1'b0;
        mwa       = idx_q;
        mwd       = {shift_q[6:0], sda_s_q};
        case (st_q)
            S_IDLE: begin
                if (cmd_valid_i) begin
                    op_d  = cmd_op_i;
                    cnt_d = cmd_count_i;
                    idx_d = cmd_start_i;
                    ph_d  = 2'd0;
                    if (cmd_op_i == OP_STOP) begin
                        if (held_q) begin
                            busy_d = 1'b1;
                            st_d   = S_STOP;
                        end else begin
                            done_d = 1'b1;
                        end
                    end else begin
                        // Held bus after a write gives a repeated start here
                        busy_d    = 1'b1;
                        st_d      = S_START;
                        addr_ph_d = 1'b1;
                        rx_d      = 1'b0;
                        bit_d     = 3'd0;
                        shift_d   = {cmd_target_address_i,
                                     (cmd_op_i == OP_READ) ? RW_READ : RW_WRITE};
                    end
                end
            end
            S_START: begin
                if (tick) begin
                    ph_d = ph_q + 2'd1;
                    case (ph_q)
                        2'd0: sda_oe_d = 1'b0;
                        2'd1: scl_oe_d = 1'b0;
                        2'd2: sda_oe_d = 1'b1;
                        default: begin
                            scl_oe_d = 1'b1;
                            st_d     = S_BIT;
                        end
                    endcase
                end
            end
            S_BIT: begin
                if (tick) begin
                    case (ph_q)
                        2'd0: begin
                            scl_oe_d = 1'b1;
                            ph_d     = 2'd1;
                        end
                        // Data moves a quarter after the clock falls, never with it
                        2'd1: begin
                            sda_oe_d = rx_q ? 1'b0 : ~shift_q[7];
                            ph_d     = 2'd2;
                        end
                        2'd2: begin
                            scl_oe_d = 1'b0;
                            ph_d     = 2'd3;
                        end
                        default: begin
                            // A target stretching the clock delays the sample
                            if (scl_s_q) begin
                                shift_d = {shift_q[6:0], sda_s_q};
                                ph_d    = 2'd0;
                                bit_d   = bit_q + 3'd1;
                                if (bit_q == 3'd7) begin
                                    st_d = S_ACK;
                                    if (rx_q) begin
                                        mwe   = 1'b1;
                                        idx_d = idx_q + 1'b1;
                                    end
                                end
                            end
                        end
                    endcase
                end
            end
            S_ACK: begin
                if (ph_q != 2'd3) begin
                    if (tick) begin
                        ph_d = ph_q + 2'd1;
                        if (ph_q == 2'd0) begin
                            scl_oe_d = 1'b1;
                        end else if (ph_q == 2'd1) begin
                            sda_oe_d = rx_q && (cnt_q != CNT_W'(1));
                        end else if (ph_q == 2'd2) begin
                            scl_oe_d = 1'b0;
                            to_d     = '0;
                        end
                    end
                end else if (rx_q) begin
                    if (tick && scl_s_q) begin
                        ph_d     = 2'd0;
                        cnt_d    = cnt_q - 1'b1;
                        if (cnt_q == CNT_W'(1)) begin
                            // Clock low first so the data line can drop for the stop
                            scl_oe_d = 1'b1;
                            status_d = 1'b1;
                            st_d     = S_STOP;
                        end else begin
                            st_d = S_BIT;
                        end
                    end
                end else if (tick && scl_s_q && !sda_s_q) begin
                    // Sampled on a tick so the ninth clock keeps its full high time
                    sda_oe_d  = 1'b0;
                    ph_d      = 2'd0;
                    addr_ph_d = 1'b0;
                    status_d  = 1'b1;
                    if (op_q == OP_READ) begin
                        if (cnt_q == '0) begin
                            scl_oe_d = 1'b1;
                            st_d     = S_STOP;
                        end else begin
                            rx_d = 1'b1;
                            st_d = S_BIT;
                        end
                    end else if (cnt_q == '0) begin
                        // Clock parked low keeps ownership for a following read
                        scl_oe_d = 1'b1;
                        st_d     = S_IDLE;
                        held_d = 1'b1;
                        busy_d = 1'b0;
                        done_d = 1'b1;
                    end else begin
                        shift_d = data_memory[idx_q];
                        idx_d   = idx_q + 1'b1;
                        cnt_d   = cnt_q - 1'b1;
                        st_d    = S_BIT;
                    end
                end else if (to_q == TO_W'(ACK_TIMEOUT_CYC - 1)) begin
                    nack_ev  = 1'b1;
                    status_d = 1'b0;
                    scl_oe_d = 1'b1;
                    ph_d     = 2'd0;
                    st_d     = S_STOP;
                end else begin
                    to_d = to_q + 1'b1;
                end
            end
            S_STOP: begin
                if (tick) begin
                    ph_d = ph_q + 2'd1;
                    case (ph_q)
                        2'd0: begin
                            scl_oe_d = 1'b1;
                            sda_oe_d = 1'b1;
                        end
                        2'd1: scl_oe_d = 1'b0;
                        2'd2: sda_oe_d = 1'b0;
                        default: begin
                            st_d   = S_IDLE;
                            held_d = 1'b0;
                            busy_d = 1'b0;
                            done_d = 1'b1;
                        end
                    endcase
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            st_q      <= S_IDLE;
            op_q      <= OP_WRITE;
            ph_q      <= '0;
            shift_q   <= '0;
            bit_q     <= '0;
            addr_ph_q <= 1'b0;
            rx_q      <= 1'b0;
            cnt_q     <= '0;
            idx_q     <= '0;
            to_q      <= '0;
            qcnt_q    <= '0;
            scl_oe_q  <= RST_PIN_OE;
            sda_oe_q  <= RST_PIN_OE;
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
            status_q  <= RST_STATUS;
            held_q    <= 1'b0;
            scl_m_q   <= 1'b1;
            scl_s_q   <= 1'b1;
            sda_m_q   <= 1'b1;
            sda_s_q   <= 1'b1;
        end else begin
            st_q      <= st_d;
            op_q      <= op_d;
            ph_q      <= ph_d;
            shift_q   <= shift_d;
            bit_q     <= bit_d;
            addr_ph_q <= addr_ph_d;
            rx_q      <= rx_d;
            cnt_q     <= cnt_d;
            idx_q     <= idx_d;
            to_q      <= to_d;
            qcnt_q    <= qcnt_d;
            scl_oe_q  <= scl_oe_d;
            sda_oe_q  <= sda_oe_d;
            busy_q    <= busy_d;
            done_q    <= done_d;
            status_q  <= status_d;
            held_q    <= held_d;
            scl_m_q   <= scl_i;
            scl_s_q   <= scl_m_q;
            sda_m_q   <= sda_i;
            sda_s_q   <= sda_m_q;
        end
    end

    // Engine store wins over a host write in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (mwe) begin
            data_memory[mwa] <= mwd;
        end else if (mem_wr_i) begin
            data_memory[mem_addr_i] <= mem_wdata_i;
        end
        mem_rdata_q <= data_memory[mem_addr_i];
    end

    // Open drain: the pins are only ever pulled low
    assign scl_o       = 1'b0;
    assign sda_o       = 1'b0;
    assign scl_oe_o    = scl_oe_q;
    assign sda_oe_o    = sda_oe_q;
    assign busy_o      = busy_q;
    assign done_o      = done_q;
    assign status_o    = status_q;
    assign mem_rdata_o = mem_rdata_q;

    a_qtr_tick_spacing: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        tick |=> !tick [*8])
        else $error("quarter tick too frequent");
    a_write_dir_low: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (st_q == S_START && op_q == OP_WRITE) |-> shift_q[0] == RW_WRITE)
        else $error("write direction bit not low");
    a_read_dir_high: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (st_q == S_START && op_q == OP_READ) |-> shift_q[0] == RW_READ)
        else $error("read direction bit not high");
    a_nack_goes_stop: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        nack_ev |=> (st_q == S_STOP && !status_q) [*2])
        else $error("missing acknowledge did not lead to stop");
    a_busy_ends_done: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (done_q && $past(busy_q)) |-> !busy_q && (st_q == S_IDLE))
        else $error("busy not cleared at completion");
    a_write_held_clk: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (done_q && op_q == OP_WRITE && status_q) |-> scl_oe_q && held_q && !sda_oe_q)
        else $error("write did not leave bus held");
    a_rx_ack_drive: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (st_q == S_ACK && rx_q && ph_q == 2'd2) |-> sda_oe_q == (cnt_q != CNT_W'(1)))
        else $error("receive acknowledge level wrong");
    a_tx_msb_first: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (st_q == S_BIT && !rx_q && ph_q == 2'd2) |-> sda_oe_q == !shift_q[7])
        else $error("transmit bit not msb first");
    a_data_clock_low: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ($changed(sda_oe_q) && (st_q == S_BIT || st_q == S_ACK)) |->
        (scl_oe_q && $past(scl_oe_q)))
        else $error("data line moved while clock released");
    a_store_ascend: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        mwe |=> idx_q == $past(idx_q) + 1'b1)
        else $error("receive index did not advance");

endmodule

// ### rtl/icm_pkg.sv
// Shared constants and types for the serial bus master transfer engine
package icm_pkg;

    // System clock and serial bus rate
    localparam int SYS_CLK_HZ     = 100_000_000;
    localparam int SCL_RATE_HZ    = 100_000;
    // Each bit is four quarter periods; exact at 100 MHz
    localparam int QTR_CYC        = SYS_CLK_HZ / (SCL_RATE_HZ * 4);

    // Acknowledge wait limit
    localparam int ACK_TIMEOUT_US  = 20;
    localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_US * (SYS_CLK_HZ / 1_000_000);

    // Default memory and count widths
    localparam int DM_AW_DEF      = 12;
    localparam int CNT_W_DEF      = 12;

    // Values after reset
    localparam logic RST_STATUS   = 1'b0;
    localparam logic RST_PIN_OE   = 1'b0;

    // Direction bit carried after the address
    localparam logic RW_WRITE     = 1'b0;
    localparam logic RW_READ      = 1'b1;

    typedef enum logic [1:0] {
        OP_WRITE,
        OP_READ,
        OP_STOP
    } icm_op_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_START,
        S_BIT,
        S_ACK,
        S_STOP
    } icm_state_t;

endpackage

// ### tb/icm_target_model.sv
// Behavioural serial bus target: acks its address, stores written bytes, serves reads
`timescale 1ns/1ps
module icm_target_model (
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic [6:0] addr_i,
    input  wire logic       slow_i,
    output logic            scl_oe_o,
    output logic            sda_oe_o
);
    logic [7:0] sh, ptr, tx, addr_byte;
    logic       sel = 1'h0;
    logic       rd, first, dv;
    int         nb = 0, phase = 0, n_start = 0, n_stop = 0;
    logic [7:0] rx_q[$];
    logic       mack_q[$];

    initial begin
        scl_oe_o = 1'h0;
        sda_oe_o = 1'h0;
    end
    // Start or repeated start
    always @(negedge sda_i) if (scl_i === 1'h1) begin
        sel = 1'h1;
        nb = 0;
        phase = 0;
        first = 1'h1;
        n_start++;
    end
    always @(posedge sda_i) if (scl_i === 1'h1) begin
        sel = 1'h0;
        n_stop++;
    end
    always @(posedge scl_i) if (sel) begin
        if (nb < 8) sh = {sh[6:0], sda_i};
        else if (phase == 2) mack_q.push_back(!sda_i);
        nb++;
    end
    // Data only changes while the clock is low, so no false start or stop
    always @(negedge scl_i) if (sel) begin
        dv = 1'h0;
        if (nb == 8 && phase == 0) begin
            addr_byte = sh;
            rd = sh[0];
            sel = (sh[7:1] == addr_i);
            dv = sel;
        end else if (nb == 8 && phase == 1) begin
            rx_q.push_back(sh);
            if (first) ptr = sh;
            first = 1'h0;
            dv = 1'h1;
        end else if (nb == 9) begin
            nb = 0;
            if (phase == 0) phase = rd ? 2 : 1;
            else if (phase == 2 && !mack_q[$]) sel = 1'h0;
            tx = ptr ^ 8'h5A;
            if (phase == 2) ptr++;
        end
        if (sel && phase == 2 && nb < 8) dv = !tx[7 - nb];
        sda_oe_o = dv;
    end
    // Slow answer: hold the clock low past the master's own low phase
    always @(negedge scl_i) if (slow_i) begin
        scl_oe_o = 1'h1;
        #6000;
        scl_oe_o = 1'h0;
    end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the serial bus master engine
`timescale 1ns/1ps
module tb_top;
    import icm_pkg::*;
    logic       sys_clk_i = 1'h0;
    logic       reset_n_i = 1'h0;
    logic       cmd_valid_i = 1'h0;
    icm_op_t    cmd_op_i = OP_STOP;
    logic [6:0] cmd_target_address_i = 7'h00;
    logic [7:0] cmd_start_i = 8'h00, cmd_count_i = 8'h00;
    logic [7:0] mem_addr_i = 8'h00, mem_wdata_i = 8'h00;
    logic       mem_wr_i = 1'h0, slow_i = 1'h0;
    logic       busy_o, done_o, status_o, scl_oe_o, sda_oe_o, t_scl_oe, t_sda_oe;
    logic       scl_o, sda_o;
    logic [7:0] mem_rdata_o, p, d, s, r, v;
    logic [6:0] ta;
    logic       scl_w, sda_w;
    int         n_fail = 0, tests_run = 0, n_clk = 0, n0, k0, c0;
    longint     t0;

    // Open-drain wires with pull-ups
    assign scl_w = !(scl_oe_o | t_scl_oe);
    assign sda_w = !(sda_oe_o | t_sda_oe);
    always #5 sys_clk_i = !sys_clk_i;
    always @(posedge scl_w) n_clk++;

    icm_master #(.ACK_TIMEOUT_CYC(600), .DM_AW(8), .CNT_W(8)) dut (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
        .cmd_op_i(cmd_op_i), .cmd_target_address_i(cmd_target_address_i),
        .cmd_start_i(cmd_start_i), .cmd_count_i(cmd_count_i), .busy_o(busy_o),
        .done_o(done_o), .status_o(status_o), .mem_wr_i(mem_wr_i), .mem_addr_i(mem_addr_i),
        .mem_wdata_i(mem_wdata_i), .mem_rdata_o(mem_rdata_o), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
    icm_target_model tgt (.scl_i(scl_w), .sda_i(sda_w), .addr_i(ta), .slow_i(slow_i),
        .scl_oe_o(t_scl_oe), .sda_oe_o(t_sda_oe));

    function automatic logic [7:0] exp_rd(input logic [7:0] base, input int k);
        return (base + 8'(k)) ^ 8'h5A;
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic mem_put(input logic [7:0] a, input logic [7:0] val);
        @(posedge sys_clk_i);
        mem_wr_i <= 1'h1;
        mem_addr_i <= a;
        mem_wdata_i <= val;
        @(posedge sys_clk_i);
        mem_wr_i <= 1'h0;
    endtask
    task automatic mem_get(input logic [7:0] a, output logic [7:0] val);
        @(posedge sys_clk_i);
        mem_addr_i <= a;
        @(posedge sys_clk_i);
        #1;
        val = mem_rdata_o;
    endtask
    // Pulse a request for one cycle, then wait for the done pulse under a bound
    task automatic run_op(input icm_op_t op, input logic [6:0] a, input logic [7:0] st,
                          input logic [7:0] n, output int cyc);
        @(posedge sys_clk_i);
        cmd_valid_i <= 1'h1;
        cmd_op_i <= op;
        cmd_target_address_i <= a;
        cmd_start_i <= st;
        cmd_count_i <= n;
        @(posedge sys_clk_i);
        cmd_valid_i <= 1'h0;
        #1;
        if (op != OP_STOP) check(busy_o, 1'h1);
        for (cyc = 0; cyc < 90000 && done_o !== 1'h1; cyc++) begin
            @(posedge sys_clk_i);
            #1;
        end
        if (cyc == 90000) begin
            n_fail++;
            end_sim();
        end else begin
            check(busy_o, 1'h0);
        end
    endtask

    initial begin
        n0 = $urandom(37);
        ta = 7'($urandom);
        s = 8'($urandom_range(0, 250));
        r = 8'($urandom_range(0, 250));
        p = 8'($urandom);
        d = 8'($urandom);
        repeat (3) @(posedge sys_clk_i);
        #1;
        check({busy_o, done_o, status_o, scl_oe_o, sda_oe_o, scl_o, sda_o}, 7'h00);
        @(posedge sys_clk_i);
        reset_n_i <= 1'h1;
        // Write of two bytes, bus left held
        mem_put(s, p);
        mem_put(s + 8'h01, d);
        k0 = tgt.n_stop;
        c0 = n_clk;
        fork
            run_op(OP_WRITE, ta, s, 8'h02, n0);
            begin
                repeat (3) @(posedge scl_w);
                t0 = $time;
                @(posedge scl_w);
                check($time - t0, 64'd10000);
            end
        join
        check(status_o, 1'h1);
        check(tgt.addr_byte, {ta, RW_WRITE});
        check(n_clk - c0, 27);
        check({tgt.rx_q[0], tgt.rx_q[1]}, {p, d});
        check({tgt.n_stop - k0, scl_w}, 0);
        // Repeated-start read against a slow target
        slow_i <= 1'h1;
        k0 = tgt.n_stop;
        c0 = n_clk;
        run_op(OP_READ, ta, r, 8'h02, n0);
        slow_i <= 1'h0;
        check(status_o, 1'h1);
        check(tgt.addr_byte, {ta, RW_READ});
        // Repeated start and stop each add one clock rise to the nine per byte
        check(n_clk - c0, 29);
        check(tgt.mack_q[0], 1'h1);
        check({tgt.mack_q[1], tgt.n_stop - k0, scl_w, sda_w}, 4'h7);
        for (int k = 0; k < 2; k++) begin
            mem_get(r + 8'(k), v);
            check(v, exp_rd(p, k));
        end
        // Lone write with a request while busy, closed by the stop operation
        k0 = tgt.n_start;
        fork
            run_op(OP_WRITE, ta, s + 8'h01, 8'h01, n0);
            begin
                repeat (200) @(posedge sys_clk_i);
                cmd_valid_i <= 1'h1;
                cmd_op_i <= OP_READ;
                @(posedge sys_clk_i);
                cmd_valid_i <= 1'h0;
            end
        join
        check(tgt.n_start - k0, 1);
        check(tgt.rx_q[2], d);
        k0 = tgt.n_stop;
        run_op(OP_STOP, ta, s, 8'h00, n0);
        check({tgt.n_stop - k0, scl_w, sda_w}, 3'h7);
        // Absent target: no data clocks, stop, status low
        c0 = n_clk;
        k0 = tgt.n_stop;
        run_op(OP_WRITE, ta ^ 7'h01, s, 8'h02, n0);
        check(status_o, 1'h0);
        check(n_clk - c0, 10);
        check({tgt.n_stop - k0, scl_w, sda_w}, 3'h7);
        // Stop with nothing held completes at once and keeps status
        run_op(OP_STOP, ta, s, 8'h00, n0);
        check(n0 <= 1, 1'h1);
        check(status_o, 1'h0);
        end_sim();
    end
endmodule
